//--- fua_pkg.sv
/*
 * Package for the flash unlock and target address front end.
 * Holds register offsets, reset values, key defaults, operation codes and
 * the packed struct that carries the flash operation request.
 * Assumes a 32-bit classic Wishbone register bus with byte offsets.
 */
// Operation
// [RQ1] Key register writable, always reads zero.
// [RQ2] Key writes form sequence guarding program flash.
// [RQ3] Target address register readable, writable, resets zero.
// [RQ4] Bulk or chip erase ignores target address.
// [RQ5] Page erase uses address to pick page.
// [RQ6] Row program uses address to pick row.
// [RQ7] Word program uses address to pick word.
// [RQ8] Operation refused without fresh complete unlock.
package fua_pkg;

    // ************************************************************
    // Register map.
    // ************************************************************
    localparam logic [7:0]  FUA_OFS_KEY     = 8'h00; // Unlock key, write only.
    localparam logic [7:0]  FUA_OFS_ADDR    = 8'h04; // Target address.
    localparam logic [7:0]  FUA_OFS_CTRL    = 8'h08; // Operation start.
    localparam logic [7:0]  FUA_OFS_STAT    = 8'h0C; // Status.
    localparam logic [31:0] FUA_ADDR_RST    = 32'h0000_0000; // Address reset.
    localparam logic [31:0] FUA_KEY_READ    = 32'h0000_0000; // Key readback.
    localparam logic [31:0] FUA_UNMAPPED    = 32'h0000_0000; // Unmapped data.
    // Control fields: bit 0 starts, bits 3:1 select operation.
    localparam int          FUA_CTRL_START  = 0;
    localparam int          FUA_CTRL_OP_LO  = 1;
    localparam int          FUA_CTRL_OP_HI  = 3;
    // Status fields.
    localparam int          FUA_STAT_UNLOCK = 0; // Key sequence complete.
    localparam int          FUA_STAT_ERR    = 1; // Last start refused.
    localparam int          FUA_STAT_BUSY   = 2; // Operation in progress.
    // Arbitrary default key values, not taken from any part.
    localparam logic [31:0] FUA_KEY1_DEF    = 32'h1234_5678;
    localparam logic [31:0] FUA_KEY2_DEF    = 32'h8765_4321;

    // ************************************************************
    // Types.
    // ************************************************************
    typedef enum logic [2:0]
    {
        FUA_OP_NONE  = 3'h0,
        FUA_OP_WORD  = 3'h1,
        FUA_OP_ROW   = 3'h3,
        FUA_OP_PAGE  = 3'h4,
        FUA_OP_BULK  = 3'h5
    } fua_op_type;

    // Operation request handed to the flash array sequencer.
    typedef struct packed
    {
        fua_op_type  op;    // Operation kind.
        logic [31:0] addr;  // Location; zero for bulk erase.
    } fua_req_type;

    // Key sequence states.
    typedef enum logic [1:0]
    {
        FUA_LOCKED,
        FUA_KEY1_SEEN,
        FUA_UNLOCKED
    } fua_key_state_type;

endpackage : fua_pkg

//--- fua_flash_front.sv
/*
 * Flash unlock key and target address front end.
 * Holds a classic Wishbone slave, the key sequence checker, the target
 * address register and the start logic for erase and program requests.
 * Assumes a flash sequencer that takes a one-cycle request pulse and
 * reports busy until the operation finishes.
 */
// The Wishbone slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module fua_flash_front
    import fua_pkg::*;
#(
    parameter logic [31:0] KEY1 = FUA_KEY1_DEF, // First key word.
    parameter logic [31:0] KEY2 = FUA_KEY2_DEF  // Second key word.
)
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output fua_req_type      flash_req,
    output logic             flash_req_valid,
    input  wire logic        flash_busy
);

    // ************************************************************
    // Bus decode.
    // ************************************************************
    // State, bus and request registers with their next values.
    logic [31:0]       addr_reg;      // Target address register.
    logic [31:0]       addr_next;     // Its next value.
    fua_key_state_type key_reg;       // Key sequence state.
    fua_key_state_type key_next;      // Its next state.
    logic              err_reg;       // Last start refused.
    logic              ack_reg;       // Bus acknowledge.
    logic [31:0]       rdat_reg;      // Registered read data.
    logic [31:0]       rdat_next;     // Read data selected.
    fua_req_type       req_reg;       // Request handed out.
    fua_req_type       req_next;      // Request built this cycle.
    logic              reqv_reg;      // Request pulse.
    logic [31:0]       wmask;         // Byte enable as bit mask.

    // A request is taken once; ack drops the cycle after it is given.
    wire acc      = wb_cyc_i & wb_stb_i & ~ack_reg;
    wire wr       = acc & wb_we_i;
    // Register selects for writes; reads never change any state.
    wire wr_key   = wr & (wb_adr_i == FUA_OFS_KEY);
    wire wr_addr  = wr & (wb_adr_i == FUA_OFS_ADDR);
    wire wr_ctrl  = wr & (wb_adr_i == FUA_OFS_CTRL);
    // Key words count only as whole 32-bit writes.
    wire full_wr  = (wb_sel_i == 4'hF);
    // Start bit of a control write; it lives in byte lane zero.
    wire start    = wr_ctrl & wb_sel_i[0] & wb_dat_i[FUA_CTRL_START];
    // Operation field and the kinds that the array sequencer knows.
    wire [2:0] op_raw = wb_dat_i[FUA_CTRL_OP_HI:FUA_CTRL_OP_LO];
    wire op_legal = (op_raw == FUA_OP_WORD) | (op_raw == FUA_OP_ROW)
                  | (op_raw == FUA_OP_PAGE) | (op_raw == FUA_OP_BULK);
    // Start only with a fresh unlock, a legal op and an idle array.
    wire start_ok = start & (key_reg == FUA_UNLOCKED) & op_legal
                  & ~flash_busy; // RQ8

    // Byte lanes expand to a bit mask for partial writes.
    // One lane of the mask for each byte of the data word.
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_mask
            assign wmask[gi*8 +: 8] = {8{wb_sel_i[gi]}};
        end
    endgenerate

    // ************************************************************
    // Target address register.
    // ************************************************************
    // Byte-lane merge of written data into the held address.
    // Lanes that are not selected keep their old bits.
    assign addr_next = wr_addr
                     ? ((addr_reg & ~wmask) | (wb_dat_i & wmask))
                     : addr_reg; // RQ3

    // Holds the address software writes.
    // Reset clears it, so software reads zero until its first write.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            addr_reg <= FUA_ADDR_RST; // RQ3
        else
            addr_reg <= addr_next;
    end

    // ************************************************************
    // Unlock key sequence.
    // ************************************************************
    // Two full-word key writes in order unlock; any other write between them relocks.
    always_comb
    begin
        key_next = key_reg;
        case (key_reg)
            FUA_LOCKED:
            begin
                // First key arms the sequence.
                if (wr_key && full_wr && wb_dat_i == KEY1)
                    key_next = FUA_KEY1_SEEN; // RQ2
            end
            FUA_KEY1_SEEN:
            begin
                // Second key must be the next write on the bus.
                if (wr_key && full_wr && wb_dat_i == KEY2)
                    key_next = FUA_UNLOCKED; // RQ2
                else if (wr)
                    key_next = FUA_LOCKED;
            end
            FUA_UNLOCKED:
            begin
                // Any write to the key, address or control register, a start included, spends or cancels unlock.
                if (wr_ctrl || wr_key || wr_addr)
                    key_next = FUA_LOCKED; // RQ8
                // A fresh first key may open a new sequence at once.
                if (wr_key && full_wr && wb_dat_i == KEY1)
                    key_next = FUA_KEY1_SEEN; // RQ2
            end
            default:
                // An unknown state falls back to locked.
                key_next = FUA_LOCKED;
        endcase
    end

    // ************************************************************
    // Request build.
    // ************************************************************
    // Bulk erase sends zero; other ops carry the target address.
    // The request leaves only through req_reg, on an accepted start.
    always_comb
    begin
        req_next.op   = fua_op_type'(op_raw);
        req_next.addr = addr_reg; // RQ5 RQ6 RQ7
        if (op_raw == FUA_OP_BULK)
            req_next.addr = 32'h0000_0000; // RQ4
    end

    // Read data selection; key reads zero always.
    // Unmapped offsets read as zero; a write there stores nothing but still breaks a key sequence.
    assign rdat_next =
        (wb_adr_i == FUA_OFS_KEY)  ? FUA_KEY_READ : // RQ1
        (wb_adr_i == FUA_OFS_ADDR) ? addr_reg :
        (wb_adr_i == FUA_OFS_CTRL) ? {28'h0, req_reg.op, 1'b0} :
        (wb_adr_i == FUA_OFS_STAT) ?
            {29'h0, flash_busy, err_reg, key_reg == FUA_UNLOCKED} :
        FUA_UNMAPPED;

    // ************************************************************
    // Bus, status and request registers.
    // ************************************************************
    // Registers the key state, acknowledge, read data and launch pulse.
    // Reset leaves the block locked with no request outstanding.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            key_reg  <= FUA_LOCKED;
            err_reg  <= 1'b0;
            ack_reg  <= 1'b0;
            rdat_reg <= 32'h0000_0000;
            req_reg  <= '0;
            reqv_reg <= 1'b0;
        end
        else
        begin
            key_reg  <= key_next;
            // Ack follows a taken request by exactly one cycle.
            ack_reg  <= acc;
            // Read data stands only in the ack cycle, zero otherwise.
            rdat_reg <= acc ? rdat_next : 32'h0000_0000;
            reqv_reg <= start_ok; // RQ8
            // The request is held until the next accepted start.
            if (start_ok)
                req_reg <= req_next;
            // A refused start is latched; an accepted one clears it.
            if (start)
                err_reg <= ~start_ok; // RQ8
        end
    end

    // Outputs come straight from flip-flops.
    assign wb_ack_o        = ack_reg;
    assign wb_dat_o        = rdat_reg; // RQ1
    assign flash_req       = req_reg;
    assign flash_req_valid = reqv_reg;

    // ************************************************************
    // Assertions.
    // ************************************************************
    // All checks sample on the rising edge and rest during reset.
    // Named key writes, used by the sequence checks.
    sequence s_key1;
        wr_key && full_wr && wb_dat_i == KEY1;
    endsequence
    sequence s_key2;
        wr_key && full_wr && wb_dat_i == KEY2;
    endsequence

    a_key_reads_zero: assert property (@(posedge mclk) disable iff (rst) // RQ1
        (acc && !wb_we_i && wb_adr_i == FUA_OFS_KEY) |=> wb_dat_o == 32'h0)
        else $error("Key register read returned nonzero.");
    // The second key right after the first unlocks.
    a_key_unlocks: assert property (@(posedge mclk) disable iff (rst) // RQ2
        (key_reg == FUA_KEY1_SEEN) ##0 s_key2 |=>
        key_reg == FUA_UNLOCKED)
        else $error("Key sequence did not unlock.");
    a_key1_arms: assert property (@(posedge mclk) disable iff (rst) // RQ2
        (key_reg == FUA_LOCKED) ##0 s_key1 |=> key_reg == FUA_KEY1_SEEN)
        else $error("First key did not arm.");
    a_addr_write: assert property (@(posedge mclk) disable iff (rst) // RQ3
        (wr_addr && full_wr) |=> addr_reg == $past(wb_dat_i))
        else $error("Address write not stored.");
    a_addr_hold: assert property (@(posedge mclk) disable iff (rst) // RQ3
        !wr_addr |=> $stable(addr_reg))
        else $error("Address changed without write.");
    a_bulk_no_addr: assert property (@(posedge mclk) disable iff (rst) // RQ4
        (flash_req_valid && flash_req.op == FUA_OP_BULK) |->
        flash_req.addr == 32'h0)
        else $error("Bulk erase carried an address.");
    a_op_addr: assert property (@(posedge mclk) disable iff (rst) // RQ5
        (start_ok && op_raw != FUA_OP_BULK) |=>
        flash_req_valid && flash_req.addr == $past(addr_reg))
        else $error("Operation address is not the target.");
    a_locked_refuse: assert property (@(posedge mclk) disable iff (rst) // RQ8
        (start && key_reg != FUA_UNLOCKED) |=> !flash_req_valid && err_reg)
        else $error("Start accepted while locked.");
    a_ack_once: assert property (@(posedge mclk) disable iff (rst)
        wb_ack_o |=> !wb_ack_o)
        else $error("Ack held for two cycles.");

    // ************************************************************
    // Bus and request checks.
    // ************************************************************
    // Every taken request is answered at the very next edge.
    a_ack_answer: assert property (@(posedge mclk) disable iff (rst)
        acc |=> wb_ack_o)
        else $error("Taken request was not acknowledged.");
    // Read data is zero whenever no acknowledge stands.
    a_dat_quiet: assert property (@(posedge mclk) disable iff (rst)
        !wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("Read data shown without acknowledge.");
    // A read of the target address returns the held value.
    a_addr_read: assert property (@(posedge mclk) disable iff (rst) // RQ3
        (acc && !wb_we_i && wb_adr_i == FUA_OFS_ADDR) |=>
        wb_dat_o == $past(addr_reg))
        else $error("Address read returned another value.");
    // Any write but the second key between the keys relocks.
    a_key_break: assert property (@(posedge mclk) disable iff (rst) // RQ2
        (key_reg == FUA_KEY1_SEEN && wr
            && !(wr_key && full_wr && wb_dat_i == KEY2))
        |=> key_reg == FUA_LOCKED)
        else $error("Interrupted key sequence did not relock.");
    // Without the first key a locked sequence stays locked.
    a_key_stays: assert property (@(posedge mclk) disable iff (rst) // RQ8
        (key_reg == FUA_LOCKED && !(wr_key && full_wr && wb_dat_i == KEY1))
        |=> key_reg == FUA_LOCKED)
        else $error("Sequence left locked without the first key.");
    // A control write spends the unlock, taken or not.
    a_unlock_spent: assert property (@(posedge mclk) disable iff (rst) // RQ8
        (key_reg == FUA_UNLOCKED && wr_ctrl) |=> key_reg == FUA_LOCKED)
        else $error("Unlock survived a control write.");
    // A busy array refuses the start and flags it.
    a_busy_refuse: assert property (@(posedge mclk) disable iff (rst) // RQ8
        (start && flash_busy) |=> !flash_req_valid && err_reg)
        else $error("Start accepted while the array was busy.");
    // An unknown operation refuses the start and flags it.
    a_op_refuse: assert property (@(posedge mclk) disable iff (rst) // RQ8
        (start && !op_legal) |=> !flash_req_valid && err_reg)
        else $error("Start accepted with an unknown operation.");
    // An accepted start clears the refused flag.
    a_err_clear: assert property (@(posedge mclk) disable iff (rst) // RQ8
        start_ok |=> !err_reg)
        else $error("Refused flag kept after an accepted start.");
    // An accepted start gives a launch pulse, with its kind.
    a_launch_kind: assert property (@(posedge mclk) disable iff (rst) // RQ8
        start_ok |=> flash_req_valid && flash_req.op == $past(op_raw))
        else $error("Launched request lost its operation kind.");
    // No launch pulse appears without an accepted start.
    a_no_launch: assert property (@(posedge mclk) disable iff (rst) // RQ8
        !start_ok |=> !flash_req_valid)
        else $error("Launch pulse without an accepted start.");
    // A taken start for each kind that uses the target address.
    sequence s_start_page;
        start_ok && op_raw == FUA_OP_PAGE;
    endsequence
    sequence s_start_row;
        start_ok && op_raw == FUA_OP_ROW;
    endsequence
    sequence s_start_word;
        start_ok && op_raw == FUA_OP_WORD;
    endsequence
    a_page_addr: assert property (@(posedge mclk) disable iff (rst) // RQ5
        s_start_page |=> flash_req.addr == $past(addr_reg))
        else $error("Page erase lost the target page.");
    a_row_addr: assert property (@(posedge mclk) disable iff (rst) // RQ6
        s_start_row |=> flash_req.addr == $past(addr_reg))
        else $error("Row program lost the target row.");
    a_word_addr: assert property (@(posedge mclk) disable iff (rst) // RQ7
        s_start_word |=> flash_req.addr == $past(addr_reg))
        else $error("Word program lost the target word.");

endmodule : fua_flash_front
`default_nettype wire

//--- tb_top.sv
/*
 * Self-checking testbench for the flash unlock and target address front end.
 * Assumes the fua_pkg offsets and default keys, a 1-cycle registered ack,
 * and a request pulse that comes with the ack of the start write.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import fua_pkg::*;
;
    // ************************************************************
    // Signals.
    // ************************************************************
    logic        mclk = 1'b0;      // 10 MHz bench clock.
    logic        rst  = 1'b1;      // Asynchronous reset, active high.
    logic        cyc  = 1'b0;      // Bus cycle.
    logic        stb  = 1'b0;      // Bus strobe.
    logic        we   = 1'b0;      // Bus direction.
    logic [7:0]  adr  = 8'h00;     // Bus byte address.
    logic [3:0]  sel  = 4'h0;      // Bus byte lanes.
    logic [31:0] dat_w = 32'h0;    // Bus write data.
    logic [31:0] dat_r;            // Bus read data.
    logic        ack;              // Bus acknowledge.
    fua_req_type req;              // Request to the array sequencer.
    logic        req_v;            // Request launch pulse.
    logic        busy = 1'b0;      // Sequencer busy input.
    logic [31:0] rd;               // Read data taken at the ack edge.
    logic        seen_v;           // Launch pulse seen at the ack edge.
    fua_req_type seen_req;         // Request seen at the ack edge.
    int          err_count = 0;    // Mismatches.
    int          samples_checked = 0; // Comparisons made.
    typedef struct { fua_op_type op; logic [31:0] a; logic [31:0] e; }
        fua_row_type;              // Operation, address written, expected.
    fua_row_type rows [4] = '{
        '{FUA_OP_WORD, 32'h0000_1004, 32'h0000_1004},
        '{FUA_OP_ROW,  32'h0000_0800, 32'h0000_0800},
        '{FUA_OP_PAGE, 32'h0000_1000, 32'h0000_1000},
        '{FUA_OP_BULK, 32'hFFFF_FFF0, 32'h0000_0000}};

    // The clock flips every half period of 50 ns.
    always #50 mclk = ~mclk;

    fua_flash_front u_dut (.mclk(mclk), .rst(rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
        .flash_req(req), .flash_req_valid(req_v), .flash_busy(busy));

    // ************************************************************
    // Tasks.
    // ************************************************************
    // Prints the counts and the verdict, then stops the run.
    task automatic summarize();
        $display("checked %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : summarize

    // Compares one value and reports a difference at once.
    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check

    // One classic bus cycle; entered and left just after a rising edge.
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [3:0] s, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= s; dat_w <= d;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            err_count++;
            $display("mismatch t=%0t bus answer never came", $time);
            summarize();
        end
        rd = dat_r;
        seen_v = req_v;
        seen_req = req;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        @(posedge mclk);
    endtask : bus

    // Writes both key words in the required order.
    task automatic unlock();
        bus(1'b1, FUA_OFS_KEY, 4'hF, FUA_KEY1_DEF);
        bus(1'b1, FUA_OFS_KEY, 4'hF, FUA_KEY2_DEF);
    endtask : unlock

    // Writes the control register with the start bit and an operation.
    task automatic start(input fua_op_type op);
        bus(1'b1, FUA_OFS_CTRL, 4'hF, {28'h0, op, 1'b1});
    endtask : start

    // ************************************************************
    // Main sequence.
    // ************************************************************
    initial
    begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        bus(1'b0, FUA_OFS_ADDR, 4'hF, 32'h0);
        check(rd, 32'h0000_0000, "address after reset");
        bus(1'b1, FUA_OFS_KEY, 4'hF, 32'hFFFF_FFFF);
        bus(1'b0, FUA_OFS_KEY, 4'hF, 32'h0);
        check(rd, 32'h0000_0000, "key readback");
        bus(1'b0, 8'h10, 4'hF, 32'h0);
        check(rd, 32'h0000_0000, "unmapped read");
        $display("test reset values done");
        // Each row: load the address, unlock, start, look at the request.
        foreach (rows[i])
        begin
            bus(1'b1, FUA_OFS_ADDR, 4'hF, rows[i].a);
            bus(1'b0, FUA_OFS_ADDR, 4'hF, 32'h0);
            check(rd, rows[i].a, "address readback");
            unlock();
            start(rows[i].op);
            check({31'h0, seen_v}, 32'h1, "launch");
            check({29'h0, seen_req.op}, {29'h0, rows[i].op}, "op");
            check(seen_req.addr, rows[i].e, "req addr");
            $display("test row %0d done", i);
        end
        // The control register shows the last launched kind, bulk.
        bus(1'b0, FUA_OFS_CTRL, 4'hF, 32'h0);
        check(rd, 32'h0000_000A, "control readback");
        // The unlock was spent by the last start; a second one is refused.
        start(FUA_OP_PAGE);
        check({31'h0, seen_v}, 32'h0, "spent unlock");
        bus(1'b0, FUA_OFS_STAT, 4'hF, 32'h0);
        check({31'h0, rd[FUA_STAT_ERR]}, 32'h1, "refused flag");
        // Keys in the wrong order, then a foreign write between the keys.
        bus(1'b1, FUA_OFS_KEY, 4'hF, FUA_KEY2_DEF);
        bus(1'b1, FUA_OFS_KEY, 4'hF, FUA_KEY1_DEF);
        start(FUA_OP_WORD);
        check({31'h0, seen_v}, 32'h0, "wrong key order");
        bus(1'b1, FUA_OFS_KEY, 4'hF, FUA_KEY1_DEF);
        bus(1'b1, FUA_OFS_ADDR, 4'hF, 32'h0000_2000);
        bus(1'b1, FUA_OFS_KEY, 4'hF, FUA_KEY2_DEF);
        start(FUA_OP_WORD);
        check({31'h0, seen_v}, 32'h0, "interrupted keys");
        // A key word written through part of the lanes does not count.
        bus(1'b1, FUA_OFS_KEY, 4'h7, FUA_KEY1_DEF);
        bus(1'b1, FUA_OFS_KEY, 4'hF, FUA_KEY2_DEF);
        start(FUA_OP_WORD);
        check({31'h0, seen_v}, 32'h0, "partial key");
        // A full unlock with an unknown operation is still refused.
        unlock();
        start(fua_op_type'(3'h2));
        check({31'h0, seen_v}, 32'h0, "unknown operation");
        $display("test key order done");
        // A busy sequencer blocks the start even when unlocked.
        busy <= 1'b1;
        unlock();
        bus(1'b0, FUA_OFS_STAT, 4'hF, 32'h0);
        check(rd, 32'h0000_0007, "status unlocked busy");
        start(FUA_OP_ROW);
        check({31'h0, seen_v}, 32'h0, "start while busy");
        busy <= 1'b0;
        $display("test busy done");
        // Byte lanes reach only the selected bytes of the address.
        bus(1'b1, FUA_OFS_ADDR, 4'hF, 32'hFFFF_FFFF);
        bus(1'b1, FUA_OFS_ADDR, 4'h1, 32'h0000_00AA);
        bus(1'b0, FUA_OFS_ADDR, 4'hF, 32'h0);
        check(rd, 32'hFFFF_FFAA, "byte lane write");
        // Reset in mid-run clears the address and the unlock state.
        unlock();
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        start(FUA_OP_WORD);
        check({31'h0, seen_v}, 32'h0, "unlock after reset");
        bus(1'b0, FUA_OFS_ADDR, 4'hF, 32'h0);
        check(rd, 32'h0000_0000, "address after second reset");
        $display("test reset done");
        summarize();
    end
endmodule : tb_top
`default_nettype wire
